//--- temp_alert_consts.vh
// offsets, reset values and field positions of the alert/offset bank
// assumes inclusion by temp_high_alert_offset_regs.v
`ifndef TEMP_ALERT_CONSTS_VH
`define TEMP_ALERT_CONSTS_VH
`define OFS_HIGH_LIMIT_LO   8'h0a
`define OFS_HIGH_LIMIT_HI   8'h0b
`define OFS_CORRECTION_LO   8'h0c
`define OFS_CORRECTION_HI   8'h0d
`define RST_HIGH_LIMIT_LO   8'hf0
`define RST_HIGH_LIMIT_HI   8'h07
`define RST_CORRECTION_LO   8'h00
`define RST_CORRECTION_HI   8'h00
`define RST_PIN_SNAPSHOT    8'hf0
`define PIN_ALERT_INDEX     2
`endif

//--- temp_high_alert_offset_regs.v
// high alert threshold, offset correction and pin snapshot registers
// assumes a scratchpad front end giving byte writes/reads and commands
// Summary of operation
// - flag high alert when corrected result exceeds limit
// - alert search answer flagged during high alert
// - supply-powered: drive alert pin low on alert
// - high limit bytes at offsets 0Ah and 0Bh
// - high limit resets to F0h low, 07h high
// - persist command writes limit and offset to memory
// - power-on restores limit and offset from memory
// - add offset to raw result before store, compare
// - offset bytes at 0Ch, 0Dh, reset 00h
// - factory and first power-up use legacy format
// - snapshot captures pins only on sample command
// - pin two snapshot shows alert when configured
// - snapshot low nibble true, high nibble inverted
// - protection bit blocks host limit and offset writes; a restore still loads them
`timescale 1ns/1ns
`default_nettype none
`include "temp_alert_consts.vh"
module temp_high_alert_offset_regs
#(
  parameter WIDTH = 16
)
(
  input  wire             core_clk,
  input  wire             rst_b,
  input  wire             regWrEn,
  input  wire [7:0]       regAddr,
  input  wire [7:0]       regWrData,
  output reg  [7:0]       regRdData,
  input  wire             protectEn,
  input  wire             supplyPowered,
  input  wire             pinTwoIsAlert,
  input  wire             persistCmd,
  output wire             nvmWrEn,
  output reg  [2*WIDTH-1:0] nvmWrData,
  input  wire             nvmRestoreEn,
  input  wire [2*WIDTH-1:0] nvmRdData,
  input  wire             convDone,
  input  wire [WIDTH-1:0] convRaw,
  output reg  [WIDTH-1:0] tempResult,
  output reg              resultValid,
  output reg              highAlertFlag,
  input  wire             conditional_flag_search_cmd,
  output wire             searchAlertBit,
  output wire             alertPinOut,
  output wire             alertPinOe_b,
  input  wire             pinSampleCmd,
  input  wire [3:0]       pinLevels
);
  localparam       NPINS    = 4;
  localparam [7:0] SNAP_RST = `RST_PIN_SNAPSHOT;

  // byte registers of the high limit and the correction
  reg  [7:0]       limitLo_q;
  reg  [7:0]       limitHi_q;
  reg  [7:0]       corrLo_q;
  reg  [7:0]       corrHi_q;
  reg  [7:0]       limitLo_d;
  reg  [7:0]       limitHi_d;
  reg  [7:0]       corrLo_d;
  reg  [7:0]       corrHi_d;
  reg              nvmWr_q;
  wire [WIDTH-1:0] highLimit;
  wire [WIDTH-1:0] correction;
  wire [WIDTH:0]   sumFull;
  wire [WIDTH-1:0] corrected;
  wire             aboveLimit;
  wire             hostWrOk;
  wire             wrLimitLo;
  wire             wrLimitHi;
  wire             wrCorrLo;
  wire             wrCorrHi;
  wire [NPINS-1:0] pinView;
  wire [NPINS-1:0] snapTrue;
  wire [NPINS-1:0] snapInv;
  wire [7:0]       snapshot;

  // host writes are dropped while protection is on
  assign hostWrOk  = regWrEn & ~protectEn;
  assign wrLimitLo = hostWrOk & (regAddr == `OFS_HIGH_LIMIT_LO);
  assign wrLimitHi = hostWrOk & (regAddr == `OFS_HIGH_LIMIT_HI);
  assign wrCorrLo  = hostWrOk & (regAddr == `OFS_CORRECTION_LO);
  assign wrCorrHi  = hostWrOk & (regAddr == `OFS_CORRECTION_HI);

  // high limit low byte; restore wins over a host write
  always @*
  begin
    limitLo_d = limitLo_q;
    if (nvmRestoreEn)
    begin
      limitLo_d = nvmRdData[WIDTH+7:WIDTH];
    end
    else if (wrLimitLo)
    begin
      limitLo_d = regWrData;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      limitLo_q <= `RST_HIGH_LIMIT_LO;
    end
    else
    begin
      limitLo_q <= limitLo_d;
    end
  end

  // high limit high byte
  always @*
  begin
    limitHi_d = limitHi_q;
    if (nvmRestoreEn)
    begin
      limitHi_d = nvmRdData[2*WIDTH-1:WIDTH+8];
    end
    else if (wrLimitHi)
    begin
      limitHi_d = regWrData;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      limitHi_q <= `RST_HIGH_LIMIT_HI;
    end
    else
    begin
      limitHi_q <= limitHi_d;
    end
  end

  // correction low byte
  always @*
  begin
    corrLo_d = corrLo_q;
    if (nvmRestoreEn)
    begin
      corrLo_d = nvmRdData[7:0];
    end
    else if (wrCorrLo)
    begin
      corrLo_d = regWrData;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      corrLo_q <= `RST_CORRECTION_LO;
    end
    else
    begin
      corrLo_q <= corrLo_d;
    end
  end

  // correction high byte
  always @*
  begin
    corrHi_d = corrHi_q;
    if (nvmRestoreEn)
    begin
      corrHi_d = nvmRdData[WIDTH-1:8];
    end
    else if (wrCorrHi)
    begin
      corrHi_d = regWrData;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      corrHi_q <= `RST_CORRECTION_HI;
    end
    else
    begin
      corrHi_q <= corrHi_d;
    end
  end

  // assembled words; formats are plain bit patterns, never converted
  assign highLimit  = {limitHi_q, limitLo_q};
  assign correction = {corrHi_q, corrLo_q};

  // offset added before store and compare; carry dropped on purpose
  assign sumFull    = {1'b0, convRaw} + {1'b0, correction};
  assign corrected  = sumFull[WIDTH-1:0];
  assign aboveLimit = $signed(corrected) > $signed(highLimit);

  // result, valid and flag change only on a finished conversion
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tempResult <= {WIDTH{1'b0}};
    end
    else if (convDone)
    begin
      tempResult <= corrected;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      resultValid <= 1'b0;
    end
    else if (convDone)
    begin
      resultValid <= 1'b1;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      highAlertFlag <= 1'b0;
    end
    else if (convDone)
    begin
      highAlertFlag <= aboveLimit;
    end
  end

  // persist request: word captured at the command edge
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      nvmWr_q <= 1'b0;
    end
    else
    begin
      nvmWr_q <= persistCmd;
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      nvmWrData <= {2*WIDTH{1'b0}};
    end
    else if (persistCmd)
    begin
      nvmWrData <= {highLimit, correction};
    end
  end

  assign nvmWrEn = nvmWr_q;

  // open-drain alert pin: value stays low, the enable pulls it
  assign searchAlertBit = conditional_flag_search_cmd & highAlertFlag;
  assign alertPinOut    = 1'b0;
  assign alertPinOe_b   = ~(supplyPowered & highAlertFlag);

  // pin snapshot: one true and one inverted bit per pin
  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1)
    begin : snapBit
      reg trueBit_q;
      reg invBit_q;

      if (i == `PIN_ALERT_INDEX)
      begin : alertView
        assign pinView[i] = pinTwoIsAlert ? alertPinOe_b : pinLevels[i];
      end
      else
      begin : plainView
        assign pinView[i] = pinLevels[i];
      end

      always @(posedge core_clk)
      begin
        if (!rst_b)
        begin
          trueBit_q <= SNAP_RST[i];
          invBit_q  <= SNAP_RST[i+NPINS];
        end
        else if (pinSampleCmd)
        begin
          trueBit_q <= pinView[i];
          invBit_q  <= ~pinView[i];
        end
      end

      assign snapTrue[i] = trueBit_q;
      assign snapInv[i]  = invBit_q;
    end
  endgenerate

  assign snapshot = {snapInv, snapTrue};

  // read side: unmapped addresses show the snapshot
  always @*
  begin
    case (regAddr)
      `OFS_HIGH_LIMIT_LO:
      begin
        regRdData = limitLo_q;
      end
      `OFS_HIGH_LIMIT_HI:
      begin
        regRdData = limitHi_q;
      end
      `OFS_CORRECTION_LO:
      begin
        regRdData = corrLo_q;
      end
      `OFS_CORRECTION_HI:
      begin
        regRdData = corrHi_q;
      end
      default:
      begin
        regRdData = snapshot;
      end
    endcase
  end
endmodule // temp_high_alert_offset_regs
`default_nettype wire

//--- cfg_store_model.sv
// config memory model: keeps the last persisted word, returns it on restore
`timescale 1ns/1ns
`default_nettype none
module cfg_store_model (input wire logic core_clk, nvmWrEn,
  input wire logic [31:0] nvmWrData, output var logic [31:0] nvmRdData);
  initial nvmRdData = 32'h0000_0000;
  always @(posedge core_clk) if (nvmWrEn) nvmRdData <= nvmWrData;
endmodule // cfg_store_model
`default_nettype wire

//--- temp_high_alert_offset_regs_monitor.sv
// port checks on the alert bank; bound to its top
`timescale 1ns/1ns
`default_nettype none
module alert_regs_monitor #(parameter WIDTH = 16) (
  input wire logic core_clk, rst_b, persistCmd, nvmWrEn, convDone,
  input wire logic highAlertFlag, searchAlertBit, supplyPowered,
  input wire logic conditional_flag_search_cmd, alertPinOut, alertPinOe_b,
  input wire logic pinSampleCmd, pinTwoIsAlert,
  input wire logic [3:0] pinLevels,
  input wire logic [7:0] regAddr, regRdData,
  input wire logic [WIDTH-1:0] tempResult);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  store_write_a: assert property (persistCmd |=> nvmWrEn)
    else $error("store");
  store_cause_a: assert property (nvmWrEn |-> $past(persistCmd))
    else $error("store");
  search_answer_a: assert property (searchAlertBit ==
    (conditional_flag_search_cmd && highAlertFlag)) else $error("search");
  alert_drive_a: assert property (alertPinOe_b ==
    !(supplyPowered && highAlertFlag)) else $error("pin");
  pin_low_a: assert property (!alertPinOut) else $error("pin");
  flag_hold_a: assert property (!convDone |=> $stable(highAlertFlag))
    else $error("flag");
  result_hold_a: assert property (!convDone |=> $stable(tempResult))
    else $error("result");
  snap_map_a: assert property (pinSampleCmd && !pinTwoIsAlert ##1
    regAddr == 8'h0e |-> regRdData == {~$past(pinLevels), $past(pinLevels)})
    else $error("snapshot");
  cover property (convDone ##1 highAlertFlag);
  cover property (persistCmd ##1 nvmWrEn);
  cover property (pinSampleCmd ##1 regAddr == 8'h0e);
endmodule // alert_regs_monitor
bind temp_high_alert_offset_regs alert_regs_monitor #(.WIDTH(WIDTH)) i_m(.*);
`default_nettype wire

//--- temp_high_alert_offset_regs_tb.sv
// bench for the alert bank; persisted words kept by cfg_store_model
`timescale 1ns/1ns
`default_nettype none
module temp_high_alert_offset_regs_tb;
  logic core_clk = 0, rst_b = 0, regWrEn = 0, protectEn = 0, convDone = 0;
  logic supplyPowered = 1, pinTwoIsAlert = 0, persistCmd = 0, alertPinOe_b;
  logic nvmRestoreEn = 0, pinSampleCmd = 0, conditional_flag_search_cmd = 1;
  logic nvmWrEn, resultValid, highAlertFlag, searchAlertBit, alertPinOut;
  logic [3:0] pinLevels = 4'h5;
  logic [7:0] regAddr = 8'h0e, regWrData = 8'h00, regRdData;
  logic [15:0] convRaw = 16'h0000, tempResult;
  logic [31:0] nvmWrData, nvmRdData;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  temp_high_alert_offset_regs i_temp_high_alert_offset_regs (.*);
  cfg_store_model i_cfg_store_model (.*);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cycles == 3000) stop_test;
  task automatic cyc(int n = 1); repeat (n) @(posedge core_clk); #1; endtask
  task automatic pulse(ref logic s); s = 1; cyc; s = 0; cyc; endtask
  task automatic chk(string s, logic [15:0] e, g);
    total_checks++;
    n_mismatch += (g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
  endtask
  task automatic rd(logic [7:0] a, e);
    regAddr = a; #1 chk("reg", e, regRdData); endtask
  task automatic wr(logic [7:0] a, d);
    regAddr = a; regWrData = d; pulse(regWrEn); endtask
  task automatic conv(logic [15:0] r, e, logic f);
    convRaw = r; pulse(convDone); chk("res", e, tempResult);
    chk("flag", f, highAlertFlag); chk("valid", 1, resultValid); endtask
  task automatic stop_test;
    n_mismatch += (cycles >= 3000);
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(6); rst_b = 1;
    rd(8'h0a, 8'hf0); rd(8'h0b, 8'h07);
    rd(8'h0d, 8'h00); rd(8'h0e, 8'hf0);
    $display("test reset end");
    wr(8'h0a, 8'h00); wr(8'h0b, 8'h01); wr(8'h0c, 8'h10);
    conv(16'h00f0, 16'h0100, 0); conv(16'h00f1, 16'h0101, 1);
    chk("srch", 1, searchAlertBit); chk("pin", 0, alertPinOe_b);
    chk("pinv", 0, alertPinOut);
    conv(16'hff00, 16'hff10, 0);
    $display("test alert end");
    protectEn = 1; wr(8'h0a, 8'h55); rd(8'h0a, 8'h00);
    protectEn = 0; pulse(persistCmd);
    chk("nvm", 16'h0100, nvmWrData[31:16]);
    wr(8'h0a, 8'h77); pulse(nvmRestoreEn); rd(8'h0a, 8'h00);
    regAddr = 8'h0e; pulse(pinSampleCmd); rd(8'h0e, 8'ha5);
    pinLevels = 4'h3; cyc; rd(8'h0e, 8'ha5);
    pinTwoIsAlert = 1; pulse(pinSampleCmd); rd(8'h0e, 8'h87);
    $display("test store end");
    stop_test;
  end
endmodule // temp_high_alert_offset_regs_tb
`default_nettype wire
